// ---- eccp_channel.v ----
// Enhanced capture/compare/PWM channel top
//
// Chosen here: the plain strobed port and the placing of the registers.
`include "eccp_defines.vh"
`default_nettype none
// How it works
// - Port latch write with pin as output may itself cause a capture.
// - Changing capture mode may set the event flag falsely.
// - Five capture prescale settings live inside the function select field.
// - Prescale counter clears when off, leaving capture, or on reset.
// - Direct prescale change keeps counter; first capture may be partial.
// - Compare value checked against selected timer pair every cycle.
// - Match sets, clears, toggles or keeps pin, and sets the flag.
// - Writing zero to control forces compare latch low, port latch kept.
// - Software interrupt compare mode only sets the flag.
// - Special trigger mode pulses an internal trigger on match.
// - Special trigger resets the selected timer pair.
// - Special trigger starts conversion only if converter already enabled.
// - PWM drives four outputs, ten-bit duty, four arrangements.
// - Arrangement codes: 00 single, 10 half, 01 forward, 11 reverse.
// - Unused outputs released; steering enables outputs in single mode.
// - PWM output waits for a new period after enable.
// - Polarity from function select; dead band is four Tosc per step.
// - Capture codes: any edge, falling, rising, every fourth, every sixteenth rising.
// - Half bridge: A modulated, B complement.
// - Forward: A active, D modulated, B and C inactive.
// - Reverse: C active, B modulated, A and D inactive.
module eccp_channel #(
  parameter TW = 16,
  parameter DBW = 7,
  parameter OSC_PER_CLK = 1
) (
  input wire mclk,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [TW-1:0] timer_count,
  input wire [7:0] pwm_timer,
  input wire pwm_period_start,
  input wire module_pin_in,
  input wire port_latch,
  input wire pin_is_output,
  input wire adc_enabled,
  input wire [3:0] steer_enable,
  output reg pwm_out_a,
  output reg pwm_out_b,
  output reg pwm_out_c,
  output reg pwm_out_d,
  output reg [3:0] pwm_out_en_n,
  output reg module_pin_out,
  output reg module_pin_oe_n,
  output reg timer_reset,
  output reg adc_start,
  output reg event_flag
);
  localparam DCW = DBW + 2;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] channel_control_reg_q;
  reg [7:0] deadband_delay_reg_q;
  reg [TW-1:0] match_capture_value_q;
  reg [3:0] presc_q;
  reg cmp_latch_q;
  reg pin_in_q;
  reg pwm_run_q;
  reg pwm_raw_q;
  reg [7:0] prev_ctrl_q;

  wire [3:0] function_select_field = channel_control_reg_q[`ECCP_FSEL_MSB:`ECCP_FSEL_LSB];
  wire [1:0] output_arrangement_field = channel_control_reg_q[`ECCP_ARR_MSB:`ECCP_ARR_LSB];
  wire [1:0] duty_lo = channel_control_reg_q[`ECCP_DUTYLO_MSB:`ECCP_DUTYLO_LSB];

  wire is_capture = (function_select_field >= `ECCP_FS_CAP_ANY) &&
                    (function_select_field <= `ECCP_FS_CAP_RISE16);
  wire is_compare = (function_select_field == `ECCP_FS_CMP_TOG) ||
                    ((function_select_field >= `ECCP_FS_CMP_HI) &&
                     (function_select_field <= `ECCP_FS_CMP_SET));
  wire is_pwm = function_select_field[3] & function_select_field[2];

  // Pin level seen by capture: the driven latch when pin is an output
  wire pin_level = pin_is_output ? port_latch : module_pin_in;
  wire rise = pin_level & ~pin_in_q;
  wire fall = ~pin_level & pin_in_q;

  // ----------------------------------------------------------------
  // Capture edge qualification
  // ----------------------------------------------------------------
  reg edge_hit;
  reg cap_event;
  always @* begin
    edge_hit = 1'b0;
    cap_event = 1'b0;
    case (function_select_field)
      `ECCP_FS_CAP_ANY: edge_hit = rise | fall;
      `ECCP_FS_CAP_FALL: edge_hit = fall;
      `ECCP_FS_CAP_RISE: edge_hit = rise;
      `ECCP_FS_CAP_RISE4: edge_hit = rise;
      `ECCP_FS_CAP_RISE16: edge_hit = rise;
      default: edge_hit = 1'b0;
    endcase
    // Prescale decides which qualifying edge captures
    if (function_select_field == `ECCP_FS_CAP_RISE4)
      cap_event = edge_hit & (presc_q[1:0] == 2'h3);
    else if (function_select_field == `ECCP_FS_CAP_RISE16)
      cap_event = edge_hit & (presc_q == 4'hF);
    else
      cap_event = edge_hit;
  end

  // Mode change between capture settings: prescaler kept, a false flag may arise
  wire ctrl_write = reg_wr && (reg_addr == `ECCP_OFS_CTRL);
  wire mode_changed = (prev_ctrl_q[3:0] != function_select_field) && is_capture;

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  wire match = is_compare && (timer_count == match_capture_value_q);
  wire set_trigger = match && (function_select_field == `ECCP_FS_CMP_SET);

  // ----------------------------------------------------------------
  // PWM generation
  // ----------------------------------------------------------------
  // Duty compared at 10 bits against timer with two fractional bits held at zero
  wire [9:0] duty10 = {match_capture_value_q[7:0], duty_lo};
  wire pwm_hi = ({pwm_timer, 2'h0} < duty10);
  // Product is formed at full width, then cut on purpose to the counter width
  wire [31:0] db_full =
    (({2'h0, deadband_delay_reg_q[DBW-1:0]} * `ECCP_DB_TOSC_PER_STEP) /
     OSC_PER_CLK);
  wire [DCW-1:0] db_cycles = db_full[DCW-1:0];
  wire db_a;
  wire db_b;

  eccp_deadband #(.CW(DCW)) u_db_a (
    .mclk(mclk),
    .reset(reset),
    .in_level(pwm_raw_q),
    .delay_cycles(db_cycles),
    .out_level(db_a)
  );
  eccp_deadband #(.CW(DCW)) u_db_b (
    .mclk(mclk),
    .reset(reset),
    .in_level(pwm_run_q & ~pwm_raw_q),
    .delay_cycles(db_cycles),
    .out_level(db_b)
  );

  // Polarity: bit1 low means A/C active high, bit0 low means B/D active high
  wire pol_ac_n = function_select_field[1];
  wire pol_bd_n = function_select_field[0];

  reg [3:0] act;
  reg [3:0] en;
  always @* begin
    act = 4'h0;
    en = 4'h0;
    case (output_arrangement_field)
      `ECCP_ARR_SINGLE: begin
        act = {4{pwm_raw_q}};
        en = steer_enable;
      end
      `ECCP_ARR_HALF: begin
        act = {2'h0, db_b, db_a};
        en = 4'h3;
      end
      `ECCP_ARR_FWD: begin
        act = {pwm_raw_q, 2'h0, 1'b1};
        en = 4'hF;
      end
      default: begin
        act = {1'b0, 1'b1, pwm_raw_q, 1'b0};
        en = 4'hF;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Register writes, capture, compare and PWM state
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      channel_control_reg_q <= `ECCP_CTRL_RST;
      deadband_delay_reg_q <= `ECCP_DEL_RST;
      match_capture_value_q <= {TW{1'b0}};
      presc_q <= 4'h0;
      cmp_latch_q <= 1'b0;
      pin_in_q <= 1'b0;
      pwm_run_q <= 1'b0;
      pwm_raw_q <= 1'b0;
      prev_ctrl_q <= 8'h00;
      event_flag <= 1'b0;
      timer_reset <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      pin_in_q <= pin_level;
      prev_ctrl_q <= channel_control_reg_q;
      timer_reset <= set_trigger;
      adc_start <= set_trigger & adc_enabled;
      if (ctrl_write)
        channel_control_reg_q <= reg_wdata;
      if (reg_wr && reg_addr == `ECCP_OFS_DEL)
        deadband_delay_reg_q <= reg_wdata;
      // Prescaler cleared when off or outside capture; kept across capture changes
      if (!is_capture)
        presc_q <= 4'h0;
      else if (edge_hit)
        presc_q <= presc_q + 4'h1;
      // Capture overwrites any unread value
      if (is_capture && cap_event)
        match_capture_value_q <= timer_count;
      else if (reg_wr && reg_addr == `ECCP_OFS_VAL_LO)
        match_capture_value_q[7:0] <= reg_wdata;
      else if (reg_wr && reg_addr == `ECCP_OFS_VAL_HI)
        match_capture_value_q[TW-1:8] <= reg_wdata[TW-9:0];
      // Compare latch action on match
      if (ctrl_write && reg_wdata == 8'h00)
        cmp_latch_q <= 1'b0;
      else if (match) begin
        case (function_select_field)
          `ECCP_FS_CMP_HI: cmp_latch_q <= 1'b1;
          `ECCP_FS_CMP_LO: cmp_latch_q <= 1'b0;
          `ECCP_FS_CMP_TOG: cmp_latch_q <= ~cmp_latch_q;
          default: cmp_latch_q <= cmp_latch_q;
        endcase
      end
      // Event flag: hardware set wins over a software clear in the same cycle
      if ((is_capture && (cap_event || mode_changed)) || match)
        event_flag <= 1'b1;
      else if (reg_wr && reg_addr == `ECCP_OFS_FLAG && reg_wdata[0])
        event_flag <= 1'b0;
      // PWM holds off until a fresh period begins
      if (!is_pwm)
        pwm_run_q <= 1'b0;
      else if (pwm_period_start)
        pwm_run_q <= 1'b1;
      pwm_raw_q <= is_pwm & (pwm_run_q | pwm_period_start) & pwm_hi;
    end
  end

  // ----------------------------------------------------------------
  // Pins and read data
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pwm_out_a <= 1'b0;
      pwm_out_b <= 1'b0;
      pwm_out_c <= 1'b0;
      pwm_out_d <= 1'b0;
      pwm_out_en_n <= 4'hF;
      module_pin_out <= 1'b0;
      module_pin_oe_n <= 1'b1;
      reg_rdata <= 8'h00;
    end else begin
      pwm_out_a <= act[0] ^ pol_ac_n;
      pwm_out_b <= act[1] ^ pol_bd_n;
      pwm_out_c <= act[2] ^ pol_ac_n;
      pwm_out_d <= act[3] ^ pol_bd_n;
      // Pins not claimed by the arrangement are released
      pwm_out_en_n <= is_pwm ? ~en : 4'hF;
      // Software-interrupt mode never drives the pin
      module_pin_out <= cmp_latch_q;
      module_pin_oe_n <= ~(is_compare && function_select_field != `ECCP_FS_CMP_SWI);
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        if (reg_addr == `ECCP_OFS_CTRL)
          reg_rdata <= channel_control_reg_q;
        else if (reg_addr == `ECCP_OFS_VAL_LO)
          reg_rdata <= match_capture_value_q[7:0];
        else if (reg_addr == `ECCP_OFS_VAL_HI)
          reg_rdata <= match_capture_value_q[TW-1:8];
        else if (reg_addr == `ECCP_OFS_DEL)
          reg_rdata <= deadband_delay_reg_q;
        else if (reg_addr == `ECCP_OFS_FLAG)
          reg_rdata <= {7'h00, event_flag};
        else if (reg_addr == `ECCP_OFS_PIN)
          reg_rdata <= {7'h00, cmp_latch_q};
        else
          reg_rdata <= 8'h00;
      end
    end
  end
endmodule // eccp_channel
`default_nettype wire

// ---- eccp_defines.vh ----
// Constants for the enhanced capture/compare/PWM channel
`ifndef ECCP_DEFINES_VH
`define ECCP_DEFINES_VH
// Register offsets on the plain register port
`define ECCP_OFS_CTRL 4'h0
`define ECCP_OFS_VAL_LO 4'h1
`define ECCP_OFS_VAL_HI 4'h2
`define ECCP_OFS_DEL 4'h3
`define ECCP_OFS_FLAG 4'h4
`define ECCP_OFS_PIN 4'h5
// Reset values
`define ECCP_CTRL_RST 8'h00
`define ECCP_DEL_RST 8'h00
// Field positions in the control register
`define ECCP_FSEL_LSB 0
`define ECCP_FSEL_MSB 3
`define ECCP_DUTYLO_LSB 4
`define ECCP_DUTYLO_MSB 5
`define ECCP_ARR_LSB 6
`define ECCP_ARR_MSB 7
// Function select codes
`define ECCP_FS_OFF 4'h0
`define ECCP_FS_CMP_TOG 4'h2
`define ECCP_FS_CAP_ANY 4'h3
`define ECCP_FS_CAP_FALL 4'h4
`define ECCP_FS_CAP_RISE 4'h5
`define ECCP_FS_CAP_RISE4 4'h6
`define ECCP_FS_CAP_RISE16 4'h7
`define ECCP_FS_CMP_HI 4'h8
`define ECCP_FS_CMP_LO 4'h9
`define ECCP_FS_CMP_SWI 4'hA
`define ECCP_FS_CMP_SET 4'hB
// Output arrangements
`define ECCP_ARR_SINGLE 2'h0
`define ECCP_ARR_FWD 2'h1
`define ECCP_ARR_HALF 2'h2
`define ECCP_ARR_REV 2'h3
// Dead band: oscillator periods per delay step
`define ECCP_DB_TOSC_PER_STEP 4
`endif

// ---- eccp_deadband.v ----
// Dead-band delay on the rising edge of one PWM phase
`default_nettype none
module eccp_deadband #(
  parameter CW = 9
) (
  input wire mclk,
  input wire reset,
  input wire in_level,
  input wire [CW-1:0] delay_cycles,
  output reg out_level
);
  reg [CW-1:0] cnt_q;
  // Output goes active only after input has been active for the delay
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_q <= {CW{1'b0}};
      out_level <= 1'b0;
    end else if (!in_level) begin
      cnt_q <= {CW{1'b0}};
      out_level <= 1'b0;
    end else if (cnt_q >= delay_cycles) begin
      out_level <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule // eccp_deadband
`default_nettype wire

// ---- eccp_channel_properties.sv ----
// Checker of compare, trigger and output release behaviour of the channel
`default_nettype none
module eccp_channel_props #(parameter TW = 16) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [TW-1:0] timer_count,
  input wire logic adc_enabled,
  input wire logic [3:0] pwm_out_en_n,
  input wire logic module_pin_out,
  input wire logic module_pin_oe_n,
  input wire logic timer_reset,
  input wire logic adc_start,
  input wire logic event_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] fs_q;
  logic [TW-1:0] cv_q;
  wire logic cmp = (fs_q[3:2] == 2'h2 || fs_q == 4'h2) && timer_count == cv_q;
  wire logic trg = cmp && fs_q == 4'hB;
  wire logic pw = fs_q[3:2] == 2'h3;
  // Shadow of function and value; captures never run in compare modes, but a value captured earlier is not seen until rewritten
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fs_q <= 4'h0;
      cv_q <= '0;
    end else if (reg_wr) begin
      if (reg_addr == 4'h0) fs_q <= reg_wdata[3:0];
      if (reg_addr == 4'h1) cv_q[7:0] <= reg_wdata;
      if (reg_addr == 4'h2) cv_q[15:8] <= reg_wdata;
    end
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  property p_flag; cmp |=> event_flag; endproperty
  a_flag: assert property (p_flag) else $error("flag missing after match");
  property p_hi; cmp && fs_q == 4'h8 |-> ##2 module_pin_out; endproperty
  a_hi: assert property (p_hi) else $error("pin not driven high");
  property p_lo; cmp && fs_q == 4'h9 |-> ##2 !module_pin_out; endproperty
  a_lo: assert property (p_lo) else $error("pin not driven low");
  property p_tog; cmp && fs_q == 4'h2 |-> ##2 module_pin_out != $past(module_pin_out); endproperty
  a_tog: assert property (p_tog) else $error("pin not toggled");
  property p_swi;
    fs_q == 4'hA && $past(fs_q) == 4'hA && $past(fs_q, 2) == 4'hA
      |-> module_pin_oe_n && $stable(module_pin_out);
  endproperty
  a_swi: assert property (p_swi) else $error("pin touched in flag only mode");
  property p_trg; trg |=> timer_reset; endproperty
  a_trg: assert property (p_trg) else $error("trigger missing");
  property p_one; timer_reset |-> $past(trg); endproperty
  a_one: assert property (p_one) else $error("trigger without match");
  property p_adc; timer_reset || adc_start |-> timer_reset && adc_start == $past(adc_enabled);
  endproperty
  a_adc: assert property (p_adc) else $error("conversion start wrong");
  property p_zero; reg_wr && reg_addr == 4'h0 && reg_wdata == 8'h00 |-> ##2 !module_pin_out;
  endproperty
  a_zero: assert property (p_zero) else $error("latch not forced low");
  property p_rel; !pw && !$past(pw) && !$past(pw, 2) |-> pwm_out_en_n == 4'hF; endproperty
  a_rel: assert property (p_rel) else $error("outputs not released");
  c_match: cover property (cmp);
  c_trig: cover property (timer_reset && adc_start);
  c_pwm: cover property (pwm_out_en_n == 4'h0);
endmodule // eccp_channel_props
bind eccp_channel eccp_channel_props #(.TW(TW)) u_props (.mclk, .reset, .reg_addr, .reg_wdata,
  .reg_wr, .timer_count, .adc_enabled, .pwm_out_en_n, .module_pin_out, .module_pin_oe_n,
  .timer_reset, .adc_start, .event_flag);
`default_nettype wire

// ---- eccp_pin_source.sv ----
// Model of the external signal source driving the module pin
`default_nettype none
module eccp_pin_source (
  input wire logic mclk,
  input wire logic reset,
  input wire logic go,
  input wire logic slow,
  input wire logic [4:0] count,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] left_q;
  logic [2:0] ph_q;
  assign busy = left_q != 6'h00;
  // Pulses change only after a clock edge, like a synchronised source; idle level is low
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      left_q <= 6'h00;
      ph_q <= 3'h0;
      pin <= 1'h0;
    end else if (go) begin
      left_q <= {count, 1'h0};
      ph_q <= 3'h0;
    end else if (busy) begin
      if (ph_q == (slow ? 3'h5 : 3'h1)) begin
        pin <= ~pin;
        left_q <= left_q - 6'h01;
        ph_q <= 3'h0;
      end else begin
        ph_q <= ph_q + 3'h1;
      end
    end
  end
endmodule // eccp_pin_source
`default_nettype wire

// ---- tb_enhanced_capture_compare_pwm.sv ----
// Self-checking testbench of the capture/compare/PWM channel
`default_nettype none
module tb_enhanced_capture_compare_pwm;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, pwm_period_start = 1'h0;
  logic port_latch = 1'h0, pin_is_output = 1'h0, adc_enabled = 1'h0, go = 1'h0, slow = 1'h0;
  logic pin, busy, pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d, module_pin_out;
  logic module_pin_oe_n, timer_reset, adc_start, event_flag;
  logic [3:0] reg_addr = 4'h0, steer_enable = 4'h0, pwm_out_en_n;
  logic [7:0] reg_wdata = 8'h00, pwm_timer = 8'h00, reg_rdata, d;
  logic [15:0] timer_count = 16'h0000;
  logic [4:0] count = 5'h00;
  int failures = 0, comparisons = 0, trig = 0, adcs = 0;
  eccp_channel DUT (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .timer_count, .pwm_timer, .pwm_period_start, .module_pin_in(pin), .port_latch,
    .pin_is_output, .adc_enabled, .steer_enable, .pwm_out_a, .pwm_out_b, .pwm_out_c,
    .pwm_out_d, .pwm_out_en_n, .module_pin_out, .module_pin_oe_n, .timer_reset, .adc_start,
    .event_flag);
  eccp_pin_source SRC (.mclk, .reset, .go, .slow, .count, .pin, .busy);
  // Clock of 100 ns period
  initial begin
    forever #50 mclk = ~mclk;
  end
  // Trigger pulses are one cycle long, so count them as they pass
  always @(posedge mclk) begin
    if (timer_reset === 1'h1) trig++;
    if (adc_start === 1'h1) adcs++;
  end
  // ----------------------------------------
  // Shared bus and checking tasks
  // ----------------------------------------
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  // Mode change through off first, then the stale flag is dropped
  task automatic setm(logic [7:0] m);
    wr(4'h0, 8'h00);
    wr(4'h0, m);
    cyc(3);
    wr(4'h4, 8'h01);
  endtask
  task automatic pulses(logic [4:0] n);
    @(posedge mclk);
    count <= n;
    go <= 1'h1;
    @(posedge mclk);
    go <= 1'h0;
    @(posedge mclk);
    for (int i = 0; i < 400 && busy; i++) @(posedge mclk);
    cyc(4);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_cap;
    logic [3:0] md [4] = '{4'h5, 4'h4, 4'h6, 4'h7};
    logic [4:0] np [4] = '{5'h01, 5'h01, 5'h04, 5'h10};
    for (int i = 0; i < 4; i++) begin
      slow <= i[1];
      timer_count <= {md[i], 12'hA5C};
      setm({4'h0, md[i]});
      pulses(np[i] - 5'h01);
      chk("early flag", event_flag, 16'h0000);
      pulses(5'h01);
      rd(4'h4);
      chk("flag", d, 16'h0001);
      rd(4'h1);
      chk("value low", d, 16'h005C);
      rd(4'h2);
      chk("value high", d, {md[i], 4'hA});
    end
    setm(8'h06);
    pulses(5'h02);
    setm(8'h06);
    pulses(5'h03);
    chk("count after off", event_flag, 16'h0000);
    setm(8'h05);
    pin_is_output <= 1'h1;
    cyc(2);
    wr(4'h4, 8'h01);
    port_latch <= 1'h1;
    cyc(4);
    chk("latch capture", event_flag, 16'h0001);
    setm(8'h03);
    port_latch <= 1'h0;
    cyc(4);
    chk("any edge", event_flag, 16'h0001);
    pin_is_output <= 1'h0;
    $display("capture tests done");
  endtask
  task automatic t_cmp;
    logic [3:0] md [7] = '{4'h8, 4'h2, 4'h2, 4'hA, 4'h9, 4'hB, 4'hB};
    logic [1:0] pe [7] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2};
    int t0, a0;
    timer_count <= 16'h0000;
    pin_is_output <= 1'h1;
    wr(4'h1, 8'h34);
    wr(4'h2, 8'h12);
    for (int i = 0; i < 7; i++) begin
      if (i == 0 || md[i] != md[i-1]) setm({4'h0, md[i]});
      if (i == 1) chk("zeroed pin", module_pin_out, 16'h0000);
      adc_enabled <= i[0];
      t0 = trig;
      a0 = adcs;
      @(posedge mclk) timer_count <= 16'h1234;
      @(posedge mclk) timer_count <= 16'h0000;
      cyc(4);
      chk("flag", event_flag, 16'h0001);
      if (pe[i] != 2'h2) chk("pin", module_pin_out, pe[i]);
      chk("pin drive", module_pin_oe_n, md[i] == 4'hA);
      chk("trigger", trig - t0, md[i] == 4'hB);
      chk("conversion", adcs - a0, md[i] == 4'hB && i[0]);
      wr(4'h4, 8'h01);
    end
    pin_is_output <= 1'h0;
    $display("compare tests done");
  endtask
  // Rows: control, duty high byte, expected {D,C,B,A}, mask, enables
  task automatic t_pwm;
    logic [27:0] rw [9] = '{28'h0CFF11E, 28'h0FFF01E, 28'h8CFF13C, 28'h8C0023C, 28'h4CFF9F0,
      28'h4C001F0, 28'hCCFF6F0, 28'hCC004F0, 28'h8CFF13C};
    logic [27:0] r;
    steer_enable <= 4'h1;
    for (int i = 0; i < 9; i++) begin
      r = rw[i];
      if (i == 8) wr(4'h3, 8'h05);
      wr(4'h1, r[19:12]);
      wr(4'h0, r[27:20]);
      if (i == 0) cyc(8);
      if (i == 0) chk("first pulse", pwm_out_a, 16'h0000);
      @(posedge mclk) pwm_period_start <= 1'h1;
      @(posedge mclk) pwm_period_start <= 1'h0;
      if (i == 8) cyc(10);
      if (i == 8) chk("dead band", pwm_out_a, 16'h0000);
      cyc(i == 8 ? 20 : 4);
      chk("outputs", {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} & r[7:4], r[11:8]);
      chk("enables", pwm_out_en_n, r[3:0]);
    end
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h00);
    cyc(4);
    chk("released", pwm_out_en_n, 16'h000F);
    rd(4'hF);
    chk("unmapped", d, 16'h0000);
    wr(4'hF, 8'hFF);
    rd(4'h0);
    chk("control", d, 16'h0000);
    $display("pwm tests done");
  endtask
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence after a 16 cycle reset
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'h0;
    t_cap();
    t_cmp();
    t_pwm();
    end_sim();
  end
  // Watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    end_sim();
  end
endmodule // tb_enhanced_capture_compare_pwm
`default_nettype wire
